// ==== stop_policy_pkg.sv ====
// constants, register map and controller states for the stop-state output block
// assumes one 100 MHz clock and a single AHB-Lite master
package stop_policy_pkg;

   localparam int NUM_IO = 8;
   localparam int CLK_MHZ = 100;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATE = 8'h04;
   localparam logic [7:0] OFS_FORCE_EN = 8'h08;
   localparam logic [7:0] OFS_FORCE_VAL = 8'h0C;
   localparam logic [7:0] OFS_DEFAULT = 8'h10;
   localparam logic [7:0] OFS_INIT = 8'h14;
   localparam logic [7:0] OFS_PTO_MASK = 8'h18;
   localparam logic [7:0] OFS_EXPERT_MASK = 8'h1C;
   localparam logic [7:0] OFS_OUT_IMAGE = 8'h20;
   localparam logic [7:0] OFS_IN_IMAGE = 8'h24;
   localparam logic [7:0] OFS_PHYS = 8'h28;
   localparam logic [7:0] OFS_CMD = 8'h2C;

   // field positions
   localparam int CTRL_POLICY_BIT = 0;
   localparam int CTRL_UPDATE_BIT = 1;
   localparam int CMD_DOWNLOAD_BIT = 0;
   localparam int CMD_WARM_BIT = 1;
   localparam int CMD_COLD_BIT = 2;
   localparam int STATE_W = 3;

   // values after reset
   localparam logic RST_POLICY = 1'b0;
   localparam logic RST_UPDATE = 1'b1;
   localparam logic [NUM_IO-1:0] RST_IO = 8'h00;

   // cyclic process data period
   localparam int PDO_PERIOD_US = 1;
   localparam int PDO_PERIOD_CYC = PDO_PERIOD_US * CLK_MHZ;
   localparam logic [7:0] PDO_CNT_LAST = 8'(PDO_PERIOD_CYC - 1);

   typedef enum logic [STATE_W-1:0] {
      ST_BOOT,
      ST_NO_FW,
      ST_EMPTY,
      ST_RUN,
      ST_RUN_ERR,
      ST_STOP
   } ctrl_state_e;

   localparam logic [STATE_W-1:0] STATE_LAST = 3'h5;

endpackage

// ==== out_source_mux.sv ====
// per-output selection of force, stop policy or task value
// purely combinational; the caller registers the result
`timescale 1ns/1ns
`default_nettype none
module out_source_mux
   import stop_policy_pkg::*;
(
   input wire logic stopMode,
   input wire logic policy,
   input wire logic [NUM_IO-1:0] ptoMask,
   input wire logic [NUM_IO-1:0] expertMask,
   input wire logic [NUM_IO-1:0] curVal,
   input wire logic [NUM_IO-1:0] defVal,
   input wire logic [NUM_IO-1:0] taskVal,
   input wire logic [NUM_IO-1:0] forceEn,
   input wire logic [NUM_IO-1:0] forceVal,
   output logic [NUM_IO-1:0] result
);
   logic [NUM_IO-1:0] policyVal;

   genvar i;
   generate
      for (i = 0; i < NUM_IO; i++)
      begin : g_bit
         // pulse train never takes its default: an extra pulse would escape
         assign policyVal[i] = ptoMask[i] ? 1'b0 :
            expertMask[i] ? (policy & defVal[i]) :
            (policy ? defVal[i] : curVal[i]);
         assign result[i] = forceEn[i] ? forceVal[i] :
            (stopMode ? policyVal[i] : taskVal[i]);
      end
   endgenerate
endmodule // out_source_mux
`default_nettype wire

// ==== can_master_ctl.sv ====
// fieldbus master gate: keeps traffic alive or sends a last pdo then goes quiet
// assumes the caller flags stop entry for exactly one cycle
`timescale 1ns/1ns
`default_nettype none
module can_master_ctl
   import stop_policy_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic keepActive,
   input wire logic lastSend,
   input wire logic [NUM_IO-1:0] imageVal,
   input wire logic [NUM_IO-1:0] stopVal,
   output logic canEnable,
   output logic tpdoSend,
   output logic [NUM_IO-1:0] tpdoData
);
   typedef struct packed {
      logic active;
      logic sendOnce;
      logic send;
      logic [7:0] tick;
      logic [NUM_IO-1:0] data;
   } can_s;

   can_s s, next_s;

   always_comb
   begin
      next_s = s;
      next_s.send = 1'b0;
      next_s.sendOnce = 1'b0;
      next_s.active = keepActive;
      if (keepActive)
      begin
         next_s.data = imageVal;
         next_s.tick = (s.tick == PDO_CNT_LAST) ? 8'h00 : s.tick + 8'h01;
         next_s.send = (s.tick == PDO_CNT_LAST);
      end
      else
         next_s.tick = 8'h00;
      if (lastSend)
      begin
         next_s.data = stopVal;
         next_s.send = 1'b1;
         next_s.sendOnce = 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         s <= '0;
      else
         s <= next_s;
   end

   // the single closing pdo still needs the bus for its one cycle
   assign canEnable = s.active | s.sendOnce;
   assign tpdoSend = s.send;
   assign tpdoData = s.data;
endmodule // can_master_ctl
`default_nettype wire

// ==== stop_state_output_policy.sv ====
// stop-state output policy block with AHB-Lite register access
// assumes field inputs synchronous to mclk and one bus master
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module stop_state_output_policy
   import stop_policy_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic runStopIn,
   input wire logic alarmTask,
   output logic alarmOut,
   input wire logic [NUM_IO-1:0] physIn,
   output logic [NUM_IO-1:0] physOut,
   output logic [NUM_IO-1:0] physOutEn,
   input wire logic [NUM_IO-1:0] taskOut,
   input wire logic taskStrobe,
   output logic taskEnable,
   output logic expertEnable,
   output logic canEnable,
   output logic tpdoSend,
   output logic [NUM_IO-1:0] tpdoData
);
   typedef struct packed {
      ctrl_state_e st;
      logic wasStop;
      logic runStopPrev;
      logic policy;
      logic policyLatched;
      logic upd;
      logic [NUM_IO-1:0] forceEn;
      logic [NUM_IO-1:0] forceVal;
      logic [NUM_IO-1:0] defVal;
      logic [NUM_IO-1:0] initVal;
      logic [NUM_IO-1:0] ptoMask;
      logic [NUM_IO-1:0] expertMask;
      logic [NUM_IO-1:0] outImage;
      logic [NUM_IO-1:0] inImage;
      logic [NUM_IO-1:0] phys;
      logic [NUM_IO-1:0] physEn;
      logic dValid;
      logic dWrite;
      logic [7:0] dAddr;
      logic [31:0] rdata;
   } ctl_s;

   ctl_s s, next_s;
   logic accept;
   logic isStop;
   logic isRun;
   logic stopEntry;
   logic [NUM_IO-1:0] forceOk;
   logic [NUM_IO-1:0] fastMask;
   logic [NUM_IO-1:0] muxOut;
   logic [NUM_IO-1:0] rdVal;

   function automatic logic isBootLike(input ctrl_state_e st);
      isBootLike = (st == ST_BOOT) || (st == ST_NO_FW) || (st == ST_EMPTY);
   endfunction

   assign accept = hsel && htrans[1] && hready;
   assign isStop = (s.st == ST_STOP);
   assign isRun = (s.st == ST_RUN) || (s.st == ST_RUN_ERR);
   assign stopEntry = isStop && !s.wasStop;
   assign fastMask = s.ptoMask | s.expertMask;
   // expert-driven outputs can never be forced
   assign forceOk = s.forceEn & ~fastMask;

   out_source_mux u_mux (
      .stopMode(isStop),
      .policy(stopEntry ? s.policy : s.policyLatched),
      .ptoMask(s.ptoMask),
      .expertMask(s.expertMask),
      .curVal(s.outImage),
      .defVal(s.defVal),
      .taskVal(taskOut),
      .forceEn(forceOk),
      .forceVal(s.forceVal),
      .result(muxOut)
   );

   can_master_ctl u_can (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .keepActive(isRun || (isStop && s.upd)),
      .lastSend(stopEntry && !s.upd),
      .imageVal(s.outImage),
      .stopVal(muxOut),
      .canEnable(canEnable),
      .tpdoSend(tpdoSend),
      .tpdoData(tpdoData)
   );

   always_comb
   begin
      case (haddr[7:0])
         OFS_CTRL: rdVal = {6'h00, s.upd, s.policy};
         OFS_STATE: rdVal = {5'h00, s.st};
         OFS_FORCE_EN: rdVal = s.forceEn;
         OFS_FORCE_VAL: rdVal = s.forceVal;
         OFS_DEFAULT: rdVal = s.defVal;
         OFS_INIT: rdVal = s.initVal;
         OFS_PTO_MASK: rdVal = s.ptoMask;
         OFS_EXPERT_MASK: rdVal = s.expertMask;
         OFS_OUT_IMAGE: rdVal = s.outImage;
         OFS_IN_IMAGE: rdVal = s.inImage;
         OFS_PHYS: rdVal = s.phys;
         default: rdVal = 8'h00;
      endcase
   end

   always_comb
   begin
      next_s = s;
      next_s.wasStop = isStop;
      next_s.runStopPrev = runStopIn;

      case (s.st)
         ST_RUN, ST_RUN_ERR:
         begin
            next_s.inImage = physIn;
            // task value plus forcing lands only when the task executes
            if (taskStrobe)
               next_s.outImage = muxOut;
            next_s.phys = s.outImage;
            next_s.physEn = {NUM_IO{1'b1}};
         end
         ST_STOP:
         begin
            next_s.physEn = {NUM_IO{1'b1}};
            if (stopEntry)
            begin
               next_s.policyLatched = s.policy;
               next_s.outImage = muxOut;
               next_s.phys = muxOut;
            end
            else if (s.upd)
            begin
               next_s.inImage = physIn;
               next_s.outImage = muxOut;
               next_s.phys = s.outImage;
            end
         end
         ST_BOOT, ST_NO_FW, ST_EMPTY:
         begin
            next_s.phys = {NUM_IO{1'b0}};
            next_s.physEn = ~fastMask;
         end
         default:
            next_s.st = ST_BOOT;
      endcase

      // the switch stays live in stop so a rising edge can restart
      if (runStopIn && !s.runStopPrev && isStop)
         next_s.st = ST_RUN;
      else if (!runStopIn && isRun)
         next_s.st = ST_STOP;

      // bus writes come last so a write in the same cycle wins
      if (s.dValid && s.dWrite)
      begin
         case (s.dAddr)
            OFS_CTRL:
            begin
               next_s.policy = hwdata[CTRL_POLICY_BIT];
               next_s.upd = hwdata[CTRL_UPDATE_BIT];
            end
            OFS_STATE:
               if (hwdata[STATE_W-1:0] <= STATE_LAST)
                  next_s.st = ctrl_state_e'(hwdata[STATE_W-1:0]);
            OFS_FORCE_EN:
               next_s.forceEn = hwdata[NUM_IO-1:0] & ~fastMask;
            OFS_FORCE_VAL: next_s.forceVal = hwdata[NUM_IO-1:0];
            OFS_DEFAULT: next_s.defVal = hwdata[NUM_IO-1:0];
            OFS_INIT: next_s.initVal = hwdata[NUM_IO-1:0];
            OFS_PTO_MASK: next_s.ptoMask = hwdata[NUM_IO-1:0];
            OFS_EXPERT_MASK: next_s.expertMask = hwdata[NUM_IO-1:0];
            OFS_OUT_IMAGE:
               next_s.outImage = hwdata[NUM_IO-1:0];
            OFS_CMD:
               if (hwdata[CMD_DOWNLOAD_BIT] || hwdata[CMD_WARM_BIT] ||
                   hwdata[CMD_COLD_BIT])
               begin
                  next_s.outImage = s.initVal;
                  next_s.inImage = s.initVal;
                  next_s.forceEn = {NUM_IO{1'b0}};
                  next_s.st = ST_STOP;
                  next_s.wasStop = 1'b0;
               end
            default:
               next_s.dValid = 1'b0;
         endcase
      end

      next_s.dValid = accept;
      next_s.dWrite = hwrite;
      next_s.dAddr = haddr[7:0];
      if (accept && !hwrite)
         next_s.rdata = {24'h000000, rdVal};
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         s <= '0;
         s.st <= ST_BOOT;
         s.policy <= RST_POLICY;
         s.policyLatched <= RST_POLICY;
         s.upd <= RST_UPDATE;
         s.outImage <= RST_IO;
         s.inImage <= RST_IO;
      end
      else
         s <= next_s;
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign alarmOut = isRun ? alarmTask : 1'b0;
   assign physOut = s.phys;
   assign physOutEn = s.physEn;
   assign taskEnable = isRun;
   assign expertEnable = isRun;

   sequence stop_begin;
      isStop && !s.wasStop;
   endsequence

   sequence held_stop;
      isStop && s.wasStop;
   endsequence

   a_alarm_low: assert property (@(posedge mclk) disable iff (sys_rst)
      isStop |-> !alarmOut)
      else $error("alarm output not low in stop");

   a_pto_zero: assert property (@(posedge mclk) disable iff (sys_rst)
      stop_begin ##0 (s.ptoMask != 8'h00) ##0 ((forceOk & s.ptoMask) == 8'h00)
      |=> ((s.phys & s.ptoMask) == 8'h00))
      else $error("pulse output not zero at stop entry");

   a_inputs_follow: assert property (@(posedge mclk) disable iff (sys_rst)
      held_stop ##0 s.upd ##0 !(s.dValid && s.dWrite)
      |=> (s.inImage == $past(physIn)))
      else $error("input image not refreshed in stop");

   a_no_task: assert property (@(posedge mclk) disable iff (sys_rst)
      isStop |-> (!taskEnable && !expertEnable))
      else $error("task or expert running in stop");

   a_inputs_frozen: assert property (@(posedge mclk) disable iff (sys_rst)
      held_stop ##0 !s.upd ##0 !(s.dValid && s.dWrite) ##1 isStop
      |-> $stable(s.inImage))
      else $error("input image moved in stop without update");

   a_pins_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      held_stop ##0 !s.upd ##1 isStop |-> $stable(physOut))
      else $error("physical outputs changed in stop without update");

   a_can_once: assert property (@(posedge mclk) disable iff (sys_rst)
      stop_begin ##0 !s.upd |=> tpdoSend ##1 (!canEnable || !isStop))
      else $error("closing pdo not sent once");

   a_can_alive: assert property (@(posedge mclk) disable iff (sys_rst)
      held_stop ##0 s.upd ##1 isStop |-> canEnable)
      else $error("fieldbus master idle in stop with update");

   a_boot_release: assert property (@(posedge mclk) disable iff (sys_rst)
      isBootLike(s.st) ##1 isBootLike(s.st)
      |-> ((physOutEn & $past(fastMask)) == 8'h00) && (physOut == 8'h00))
      else $error("outputs not released in boot states");

   a_force_wins: assert property (@(posedge mclk) disable iff (sys_rst)
      isRun && taskStrobe && (forceOk != 8'h00) && !(s.dValid && s.dWrite)
      |=> (((s.outImage ^ $past(s.forceVal)) & $past(forceOk)) == 8'h00))
      else $error("forced value lost on task write");

   a_force_reject: assert property (@(posedge mclk) disable iff (sys_rst)
      isRun && taskStrobe && !(s.dValid && s.dWrite)
      |=> (((s.outImage ^ $past(taskOut)) & $past(fastMask)) == 8'h00))
      else $error("force applied to expert output");
endmodule // stop_state_output_policy
`default_nettype wire

// ==== field_io_model.sv ====
// field side model: drives the physical inputs and listens to the fieldbus
// assumes the bench sets fieldVal just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module field_io_model
   import stop_policy_pkg::*;
(
   input wire logic mclk,
   input wire logic [NUM_IO-1:0] fieldVal,
   input wire logic canEnable,
   input wire logic tpdoSend,
   input wire logic [NUM_IO-1:0] tpdoData,
   output logic [NUM_IO-1:0] physIn,
   output int pdoCount,
   output logic [NUM_IO-1:0] pdoLast
);
   initial pdoCount = 0;
   initial pdoLast = '0;
   assign physIn = fieldVal;
   // a pdo sent while the master is off the bus would never be heard
   always @(posedge mclk)
   begin
      if (tpdoSend === 1'b1 && canEnable === 1'b1)
      begin
         pdoCount <= pdoCount + 1;
         pdoLast <= tpdoData;
      end
   end
endmodule // field_io_model
`default_nettype wire

// ==== test_stop_state_output_policy.sv ====
// self-checking bench for the stop-state output block
// assumes zero-wait bus answers; read results go through a queue
`timescale 1ns/1ns
`default_nettype none
module test_stop_state_output_policy
   import stop_policy_pkg::*;
;
   logic mclk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic runStopIn, alarmTask, alarmOut, taskStrobe, taskEnable;
   logic expertEnable, canEnable, tpdoSend, rdPend;
   logic [NUM_IO-1:0] physIn, physOut, physOutEn, taskOut, tpdoData;
   logic [NUM_IO-1:0] fieldVal, pdoLast, t, p;
   int pdoCount, mismatches, checked, n, k;
   logic [31:0] expQ[$];

   assign hready = hreadyout;
   always #5 mclk = ~mclk;

   stop_state_output_policy uut (.mclk(mclk), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .runStopIn(runStopIn), .alarmTask(alarmTask), .alarmOut(alarmOut),
      .physIn(physIn), .physOut(physOut), .physOutEn(physOutEn),
      .taskOut(taskOut), .taskStrobe(taskStrobe), .taskEnable(taskEnable),
      .expertEnable(expertEnable), .canEnable(canEnable),
      .tpdoSend(tpdoSend), .tpdoData(tpdoData));

   field_io_model field (.mclk(mclk), .fieldVal(fieldVal),
      .canEnable(canEnable), .tpdoSend(tpdoSend), .tpdoData(tpdoData),
      .physIn(physIn), .pdoCount(pdoCount), .pdoLast(pdoLast));

   task automatic test_done;
      if (mismatches == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // the edge that ends a read's data phase sees hrdata before any update
   always @(posedge mclk)
   begin
      if (rdPend && expQ.size() > 0)
         check(hrdata, expQ.pop_front());
      rdPend <= hsel && htrans[1] && !hwrite && hready;
   end

   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
   endtask

   task automatic waitRdy;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         mismatches++;
         test_done;
      end
   endtask

   task automatic busWrite(input logic [7:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= 32'(a);
      hwrite <= 1'b1;
      htrans <= 2'b10;
      waitRdy;
      htrans <= 2'b00;
      hwdata <= 32'(d);
      waitRdy;
   endtask

   task automatic busRead(input logic [7:0] a, input logic [7:0] e);
      hsel <= 1'b1;
      haddr <= 32'(a);
      hwrite <= 1'b0;
      htrans <= 2'b10;
      waitRdy;
      htrans <= 2'b00;
      expQ.push_back(32'(e));
      waitRdy;
   endtask

   task automatic strobe(input logic [7:0] v);
      taskOut <= v;
      taskStrobe <= 1'b1;
      @(posedge mclk);
      taskStrobe <= 1'b0;
      cyc(3);
   endtask

   task automatic waitPdo(input logic [7:0] e);
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (tpdoSend !== 1'b1 && n < 200);
      if (tpdoSend !== 1'b1)
      begin
         mismatches++;
         test_done;
      end
      check(32'(tpdoData), 32'(e));
   endtask

   initial
   begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = '0;
      runStopIn = 1'b1;
      alarmTask = 1'b1;
      taskOut = '0;
      taskStrobe = 1'b0;
      fieldVal = '0;
      rdPend = 1'b0;
      mismatches = 0;
      checked = 0;
      void'($urandom(44));
      cyc(12);
      sys_rst <= 1'b0;
      @(posedge mclk);
      busRead(OFS_CTRL, 8'h02);
      busRead(OFS_STATE, 8'h00);
      busWrite(OFS_PTO_MASK, 8'h01);
      busWrite(OFS_EXPERT_MASK, 8'h02);
      for (int s = 0; s < 3; s++)
      begin
         busWrite(OFS_STATE, 8'(s));
         cyc(3);
         check(32'(physOut), 32'h0);
         check(32'(physOutEn), 32'hFC);
         check(32'(alarmOut), 32'h0);
      end
      busWrite(OFS_STATE, 8'h03);
      fieldVal <= 8'($urandom);
      cyc(3);
      check(32'({taskEnable, expertEnable, alarmOut}), 32'h7);
      busRead(OFS_IN_IMAGE, fieldVal);
      t = 8'($urandom);
      strobe(t);
      check(32'(physOut), 32'(t));
      busWrite(OFS_FORCE_VAL, 8'h81);
      busWrite(OFS_FORCE_EN, 8'h85);
      cyc(3);
      check(32'(physOut), 32'(t));
      busRead(OFS_FORCE_EN, 8'h84);
      t = 8'($urandom);
      strobe(t);
      check(32'(physOut), 32'((t & 8'h7B) | 8'h80));
      // stop with inputs and outputs still refreshed, keep policy
      runStopIn <= 1'b0;
      cyc(5);
      p = (t & 8'h78) | 8'h80;
      check(32'(physOut), 32'(p));
      check(32'({taskEnable, expertEnable, alarmOut, canEnable}), 32'h1);
      fieldVal <= 8'($urandom);
      cyc(2);
      busRead(OFS_IN_IMAGE, fieldVal);
      waitPdo(p);
      strobe(~p);
      check(32'(physOut), 32'(p));
      // back to run, then a frozen stop under the defaults policy
      runStopIn <= 1'b1;
      cyc(3);
      busWrite(OFS_DEFAULT, 8'hA7);
      busWrite(OFS_FORCE_VAL, 8'h00);
      busWrite(OFS_FORCE_EN, 8'h20);
      busWrite(OFS_CTRL, 8'h01);
      runStopIn <= 1'b0;
      cyc(10);
      check(32'(physOut), 32'h86);
      check(32'(pdoLast), 32'h86);
      k = pdoCount;
      cyc(300);
      check(32'(pdoCount), 32'(k));
      check(32'(canEnable), 32'h0);
      p = fieldVal;
      fieldVal <= ~p;
      cyc(2);
      busRead(OFS_IN_IMAGE, p);
      busWrite(OFS_OUT_IMAGE, 8'h33);
      busRead(OFS_OUT_IMAGE, 8'h33);
      check(32'(physOut), 32'h86);
      for (int i = 0; i < 3; i++)
      begin
         t = 8'(8'h11 * (i + 1));
         busWrite(OFS_FORCE_EN, 8'h10);
         busWrite(OFS_INIT, t);
         busWrite(OFS_CMD, 8'(1 << i));
         busRead(OFS_OUT_IMAGE, t);
         busRead(OFS_IN_IMAGE, t);
         busRead(OFS_FORCE_EN, 8'h00);
         busRead(OFS_STATE, 8'h05);
      end
      busWrite(8'h30, 8'hFF);
      busRead(8'h30, 8'h00);
      busWrite(OFS_STATE, 8'h07);
      busRead(OFS_STATE, 8'h05);
      runStopIn <= 1'b1;
      cyc(2);
      busRead(OFS_STATE, 8'h03);
      busWrite(OFS_STATE, 8'h04);
      busRead(OFS_STATE, 8'h04);
      t = 8'($urandom);
      strobe(t);
      check(32'(physOut), 32'(t));
      check(32'({taskEnable, expertEnable, alarmOut}), 32'h7);
      check(32'({hresp, hreadyout}), 32'h1);
      test_done;
   end
endmodule // test_stop_state_output_policy
`default_nettype wire
